// ---- core/dhtmr_pkg.sv ----
package dhtmr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG    = 8'h00; // bit0 combine to 32 bit, bit1 rtc mode
  localparam logic [7:0] OFS_CTL    = 8'h04; // bit0 run first, bit1 run second, bit4 rtc count
  localparam logic [7:0] OFS_LOAD_A = 8'h08;
  localparam logic [7:0] OFS_LOAD_B = 8'h0c;
  localparam logic [7:0] OFS_MTCH_A = 8'h10;
  localparam logic [7:0] OFS_MTCH_B = 8'h14;
  localparam logic [7:0] OFS_PRE    = 8'h18; // [7:0] first, [15:8] second
  localparam logic [7:0] OFS_PMT    = 8'h1c; // [7:0] first, [15:8] second
  localparam logic [7:0] OFS_VAL_A  = 8'h20;
  localparam logic [7:0] OFS_VAL_B  = 8'h24;
  localparam logic [7:0] OFS_RIS    = 8'h28;
  localparam logic [7:0] OFS_IMR    = 8'h2c;
  localparam logic [7:0] OFS_MIS    = 8'h30;
  localparam logic [7:0] OFS_PRE_WR = 8'h34; // [1:0] half select, [15:8] prescale, [23:16] match
  // field positions
  localparam int CFG_COMB  = 0;
  localparam int CFG_RTC   = 1;
  localparam int CTL_RUN_A = 0;
  localparam int CTL_RUN_B = 1;
  localparam int CTL_RTCEN = 4;
  localparam int IRQ_TO_A  = 0;
  localparam int IRQ_MT_A  = 1;
  localparam int IRQ_RTC   = 3;
  localparam int IRQ_TO_B  = 8;
  localparam int IRQ_MT_B  = 9;
  localparam logic [31:0] IRQ_MASK_ALL = 32'h0000_030b;
  // reset values
  localparam logic [31:0] RST_LOAD = 32'hffff_ffff;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : dhtmr_pkg

// ---- core/dhtmr_half_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// configuration and status of one sixteen bit half
interface dhtmr_half_if;
  logic        run;
  logic        load_wr;
  logic [15:0] load;
  logic [15:0] match;
  logic [7:0]  pre;
  logic [7:0]  pmatch;
  logic [15:0] value;
  logic [7:0]  pcount;
  logic        timeout;
  logic        hit;
  modport ctrl (output run, load_wr, load, match, pre, pmatch,
                input value, pcount, timeout, hit);
  modport half (input run, load_wr, load, match, pre, pmatch,
                output value, pcount, timeout, hit);
endinterface : dhtmr_half_if
`default_nettype wire

// ---- core/dhtmr_half.sv ----
`timescale 1ns/1ps
`default_nettype none
// one prescaled sixteen bit down counter
module dhtmr_half (
  input  wire logic   clock,
  input  wire logic   reset_n,
  dhtmr_half_if.half  hf
);
  import dhtmr_pkg::*;
  logic tick;
  // prescaler expiry advances the main count once
  assign tick = (hf.pcount == 8'h00);

  // prescaler is the low-order extension of the count
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hf.pcount <= 8'h00;
    end else if (hf.load_wr || !hf.run || tick) begin
      hf.pcount <= hf.pre;
    end else begin
      hf.pcount <= hf.pcount - 8'h01;
    end
  end

  // main count; load write takes effect at once; the top raises load_wr only while the run bit of the half is set
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hf.value <= 16'hffff;
    end else if (hf.load_wr) begin
      hf.value <= hf.load;
    end else if (hf.run && tick) begin
      hf.value <= (hf.value == 16'h0000) ? hf.load : hf.value - 16'h0001;
    end
  end

  // events are one-cycle pulses
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hf.timeout <= 1'b0;
      hf.hit     <= 1'b0;
    end else begin
      hf.timeout <= hf.run && tick && !hf.load_wr && (hf.value == 16'h0000);
      // 24 bit compare: prescale match joins the 16 bit match
      hf.hit <= hf.run && !hf.load_wr &&
                ({hf.value, hf.pcount} == {hf.match, hf.pmatch});
    end
  end
endmodule : dhtmr_half
`default_nettype wire

// ---- core/dhtmr_top.sv ----
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dhtmr_top (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             pwm_a,
  output logic             pwm_b
);
  import dhtmr_pkg::*;

  typedef enum logic [1:0] {
    DHT_SEL_NONE = 2'b00,
    DHT_SEL_A    = 2'b01,
    DHT_SEL_B    = 2'b10,
    DHT_SEL_BOTH = 2'b11
  } dhtmr_sel_t;

  dhtmr_half_if ha ();
  dhtmr_half_if hb ();

  logic [1:0]  cfg_q;
  logic [4:0]  ctl_q;
  logic [31:0] load_q;
  logic [31:0] mtch_q;
  logic [7:0]  pre_a_q, pre_b_q, pmt_a_q, pmt_b_q;
  logic [31:0] cnt32_q;
  logic [31:0] ris_q, imr_q;
  logic        wr_en, rd_en, known;
  logic [31:0] rd_d;
  logic        comb, rtc_run, run_a, run_b, to32, mt32, rtc_hit;
  logic [31:0] ev;
  dhtmr_sel_t  sel;

  // first access cycle only; pready marks the second, so nothing lands twice
  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  assign comb  = cfg_q[CFG_COMB];
  assign sel   = dhtmr_sel_t'(pwdata[1:0]);

  // rtc count only meaningful in rtc mode
  assign rtc_run = cfg_q[CFG_RTC] && ctl_q[CTL_RTCEN];
  assign run_a   = cfg_q[CFG_RTC] ? 1'b0 : ctl_q[CTL_RUN_A];
  assign run_b   = (cfg_q[CFG_RTC] || comb) ? 1'b0 : ctl_q[CTL_RUN_B];

  // decode helper used by the write path
  function automatic logic hit_ofs(input logic [7:0] a, input logic [7:0] o);
    hit_ofs = (a == o);
  endfunction : hit_ofs

  // configuration and control
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cfg_q <= 2'b00;
      ctl_q <= 5'h00;
    end else if (wr_en) begin
      if (hit_ofs(paddr, OFS_CFG)) cfg_q <= pwdata[1:0];
      if (hit_ofs(paddr, OFS_CTL)) ctl_q <= pwdata[4:0];
    end
  end

  // load and match; in combined mode the first half registers hold all 32 bits
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      load_q <= RST_LOAD;
      mtch_q <= RST_ZERO;
    end else if (wr_en) begin
      if (hit_ofs(paddr, OFS_LOAD_A))
        load_q <= comb ? pwdata : {load_q[31:16], pwdata[15:0]};
      if (hit_ofs(paddr, OFS_LOAD_B) && !comb) load_q[31:16] <= pwdata[15:0];
      if (hit_ofs(paddr, OFS_MTCH_A))
        mtch_q <= comb ? pwdata : {mtch_q[31:16], pwdata[15:0]};
      if (hit_ofs(paddr, OFS_MTCH_B) && !comb) mtch_q[31:16] <= pwdata[15:0];
    end
  end

  // prescale registers; 8 bits wide so values above 255 cannot be held
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pre_a_q <= 8'h00;
      pre_b_q <= 8'h00;
      pmt_a_q <= 8'h00;
      pmt_b_q <= 8'h00;
    end else if (wr_en) begin
      if (hit_ofs(paddr, OFS_PRE)) begin
        pre_a_q <= pwdata[7:0];
        pre_b_q <= pwdata[15:8];
      end
      if (hit_ofs(paddr, OFS_PMT)) begin
        pmt_a_q <= pwdata[7:0];
        pmt_b_q <= pwdata[15:8];
      end
      // selective update of either or both halves
      if (hit_ofs(paddr, OFS_PRE_WR)) begin
        if (sel == DHT_SEL_A || sel == DHT_SEL_BOTH) begin
          pre_a_q <= pwdata[15:8];
          pmt_a_q <= pwdata[23:16];
        end
        if (sel == DHT_SEL_B || sel == DHT_SEL_BOTH) begin
          pre_b_q <= pwdata[15:8];
          pmt_b_q <= pwdata[23:16];
        end
      end
    end
  end

  // drive the two halves; the prescaler is bypassed outside 16 bit modes
  always_comb begin
    ha.run     = run_a && !comb;
    ha.load_wr = wr_en && hit_ofs(paddr, OFS_LOAD_A) && !comb && ctl_q[CTL_RUN_A];
    // load_q changes on the same edge, so a running reload takes the bus word
    ha.load    = ha.load_wr ? pwdata[15:0] : load_q[15:0];
    ha.match   = mtch_q[15:0];
    ha.pre     = pre_a_q;
    ha.pmatch  = pmt_a_q;
    hb.run     = run_b;
    hb.load_wr = wr_en && hit_ofs(paddr, OFS_LOAD_B) && !comb && ctl_q[CTL_RUN_B];
    hb.load    = hb.load_wr ? pwdata[15:0] : load_q[31:16];
    hb.match   = mtch_q[31:16];
    hb.pre     = pre_b_q;
    hb.pmatch  = pmt_b_q;
  end

  dhtmr_half u_half_a (
    .clock   (clock),
    .reset_n (reset_n),
    .hf      (ha)
  );

  dhtmr_half u_half_b (
    .clock   (clock),
    .reset_n (reset_n),
    .hf      (hb)
  );

  // 32 bit counter: no prescaler; counts down in timer use, up in rtc use
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt32_q <= RST_LOAD;
    end else if (wr_en && hit_ofs(paddr, OFS_LOAD_A) && comb) begin
      cnt32_q <= pwdata;
    end else if (rtc_run) begin
      cnt32_q <= cnt32_q + 32'h0000_0001;
    end else if (comb && ctl_q[CTL_RUN_A] && !cfg_q[CFG_RTC]) begin
      cnt32_q <= (cnt32_q == 32'h0000_0000) ? load_q : cnt32_q - 32'h0000_0001;
    end
  end

  assign to32    = comb && ctl_q[CTL_RUN_A] && !cfg_q[CFG_RTC] && cnt32_q == 32'h0000_0000;
  assign mt32    = comb && ctl_q[CTL_RUN_A] && !cfg_q[CFG_RTC] && cnt32_q == mtch_q;
  assign rtc_hit = rtc_run && cnt32_q == mtch_q;

  // event vector in status layout
  always_comb begin
    ev = 32'h0000_0000;
    ev[IRQ_TO_A] = ha.timeout || to32;
    ev[IRQ_MT_A] = ha.hit || mt32;
    ev[IRQ_RTC]  = rtc_hit;
    ev[IRQ_TO_B] = hb.timeout;
    ev[IRQ_MT_B] = hb.hit;
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ris_q <= RST_ZERO;
    end else begin
      ris_q <= ((ris_q & ~((wr_en && hit_ofs(paddr, OFS_RIS)) ? pwdata : 32'h0000_0000))
               | ev) & IRQ_MASK_ALL;
    end
  end

  // interrupt mask
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      imr_q <= RST_ZERO;
    end else if (wr_en && hit_ofs(paddr, OFS_IMR)) begin
      imr_q <= pwdata & IRQ_MASK_ALL;
    end
  end

  // disabled sources never reach the interrupt line
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ris_q & imr_q);
    end
  end

  // pwm outputs: high while count is below the match value
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pwm_a <= 1'b0;
      pwm_b <= 1'b0;
    end else begin
      pwm_a <= comb ? (ctl_q[CTL_RUN_A] && cnt32_q < mtch_q)
                    : (ha.run && ha.value < ha.match);
      pwm_b <= hb.run && hb.value < hb.match;
    end
  end

  // read decode; reads have no side effect on counting
  always_comb begin
    known = 1'b1;
    rd_d  = 32'h0000_0000;
    case (paddr)
      OFS_CFG:    rd_d = {30'h0, cfg_q};
      OFS_CTL:    rd_d = {27'h0, ctl_q};
      OFS_LOAD_A: rd_d = comb ? load_q : {16'h0, load_q[15:0]};
      OFS_LOAD_B: rd_d = {16'h0, load_q[31:16]};
      OFS_MTCH_A: rd_d = comb ? mtch_q : {16'h0, mtch_q[15:0]};
      OFS_MTCH_B: rd_d = {16'h0, mtch_q[31:16]};
      OFS_PRE:    rd_d = {16'h0, pre_b_q, pre_a_q};
      OFS_PMT:    rd_d = {16'h0, pmt_b_q, pmt_a_q};
      OFS_VAL_A:  rd_d = (comb || cfg_q[CFG_RTC]) ? cnt32_q : {16'h0, ha.value};
      OFS_VAL_B:  rd_d = {16'h0, hb.value};
      OFS_RIS:    rd_d = ris_q;
      OFS_IMR:    rd_d = imr_q;
      OFS_MIS:    rd_d = ris_q & imr_q;
      OFS_PRE_WR: rd_d = 32'h0000_0000;
      default:    known = 1'b0;
    endcase
  end

  // apb answer: registered, one wait state, pready pulses for one cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_ZERO;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !known;
      prdata  <= rd_en ? rd_d : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : dhtmr_top
`default_nettype wire

// ---- sim/dhtmr_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// bus and interrupt watcher for the timer top
module dhtmr_monitor
  import dhtmr_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        pwm_a,
  input wire logic        pwm_b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // one wait state, then a single answer cycle
  property p_wait_one; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  property p_unmapped; pready && paddr > OFS_PRE_WR |-> pslverr && prdata == 32'h0; endproperty
  // prescale fields are eight bits per half, nothing above
  property p_pre_width;
    pready && !pwrite && (paddr == OFS_PRE || paddr == OFS_PMT) |-> prdata[31:16] == 16'h0;
  endproperty
  property p_mis_bits;
    pready && !pwrite && paddr == OFS_MIS |-> (prdata & ~IRQ_MASK_ALL) == 32'h0;
  endproperty
  property p_reset_quiet; $rose(reset_n) |-> !irq && !pready && !pslverr && prdata == 32'h0;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait state");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_pre_width: assert property (p_pre_width) else $error("prescale field too wide");
  a_mis_bits: assert property (p_mis_bits) else $error("masked status has stray bits");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active out of reset");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_mis: cover property (pready && !pwrite && paddr == OFS_MIS && prdata != 32'h0);
endmodule : dhtmr_monitor

bind dhtmr_top dhtmr_monitor u_mon (.clock(clock), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .pwm_a(pwm_a), .pwm_b(pwm_b));
`default_nettype wire

// ---- sim/test_dual_half_timer_prescale_rtc.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_dual_half_timer_prescale_rtc;
  import dhtmr_pkg::*;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, irq, e, pwm_a, pwm_b;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, r, r2, x_pre, x_pmt, hi;
  int          err_count, num_checks;

  dhtmr_top DUT (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pwm_a(pwm_a), .pwm_b(pwm_b));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // selective write touches only the chosen halves
  function automatic logic [31:0] merge(input logic [31:0] o, input int s, input logic [7:0] v);
    return {16'h0, s[1] ? v : o[15:8], s[0] ? v : o[7:0]};
  endfunction : merge

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk_val(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask : chk_val
  task automatic chk_flag(input logic c);
    num_checks++;
    if (c !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t condition false", $time);
    end
  endtask : chk_flag
  // one apb transfer; holds everything until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      $display("MISMATCH %0t no pready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  initial begin
    #(100 * 5000);
    err_count++;
    give_verdict();
  end

  initial begin
    psel <= 0; penable <= 0; pwrite <= 0; paddr <= 0; pwdata <= 0; reset_n <= 0;
    err_count = 0; num_checks = 0; seed = 32'd58; x_pmt = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    apb(0, OFS_PRE, 0); chk_val(r, 32'h0);
    apb(0, OFS_PMT, 0); chk_val(r, 32'h0);
    apb(0, OFS_RIS, 0); chk_val(r, 32'h0);
    apb(0, 8'h40, 0); chk_val(r, 32'h0);
    chk_flag(e);
    // random prescale values, full range both halves
    repeat (6) begin
      seed = xs(seed);
      x_pre = {16'h0, seed[15:0]};
      x_pmt = {16'h0, seed[31:16]};
      apb(1, OFS_PRE, x_pre); apb(0, OFS_PRE, 0); chk_val(r, x_pre);
      apb(1, OFS_PMT, x_pmt); apb(0, OFS_PMT, 0); chk_val(r, x_pmt);
    end
    for (int s = 1; s < 4; s++) begin
      seed = xs(seed);
      apb(1, OFS_PRE_WR, {8'h0, seed[23:8], 6'h0, s[1:0]});
      x_pre = merge(x_pre, s, seed[15:8]);
      x_pmt = merge(x_pmt, s, seed[23:16]);
      apb(0, OFS_PRE, 0); chk_val(r, x_pre);
      apb(0, OFS_PMT, 0); chk_val(r, x_pmt);
    end
    // rtc enable outside rtc mode must leave a stopped count alone
    apb(1, OFS_CFG, 0); apb(1, OFS_CTL, 32'h1 << CTL_RTCEN);
    apb(0, OFS_VAL_A, 0); r2 = r; repeat (5) @(posedge clock);
    apb(0, OFS_VAL_A, 0); chk_val(r, r2);
    apb(1, OFS_CFG, 32'h1 << CFG_RTC); apb(1, OFS_CTL, 32'h1 << CTL_RTCEN);
    // count left reset value only once rtc mode came on, so it is still small
    apb(0, OFS_VAL_A, 0); r2 = r; chk_flag(r2 < 32'h10);
    repeat (5) @(posedge clock);
    apb(0, OFS_VAL_A, 0); chk_flag((r - r2) inside {[6:20]});
    apb(1, OFS_CTL, 0); apb(0, OFS_VAL_A, 0); r2 = r; repeat (5) @(posedge clock);
    apb(0, OFS_VAL_A, 0); chk_val(r, r2);
    // short reload on a running half; raw status set while masked
    apb(1, OFS_CFG, 0); apb(1, OFS_PRE, 0); apb(1, OFS_IMR, 0);
    apb(1, OFS_CTL, 32'h1 << CTL_RUN_A); apb(1, OFS_LOAD_A, 32'h5);
    apb(0, OFS_VAL_A, 0); chk_flag(r[15:0] <= 16'h5);
    apb(0, OFS_PMT, 0); chk_val(r, x_pmt);
    apb(0, OFS_RIS, 0); chk_flag(r[IRQ_TO_A]);
    chk_flag(r[IRQ_RTC]);
    apb(0, OFS_MIS, 0); chk_val(r, 32'h0);
    chk_flag(irq === 1'b0);
    apb(1, OFS_IMR, 32'h1 << IRQ_TO_A); repeat (2) @(posedge clock); #1;
    chk_flag(irq);
    apb(0, OFS_MIS, 0); chk_flag(r[IRQ_TO_A]);
    apb(1, OFS_CTL, 0); apb(1, OFS_RIS, 32'h1 << IRQ_TO_A);
    apb(0, OFS_RIS, 0); chk_flag(!r[IRQ_TO_A]);
    repeat (2) @(posedge clock); #1;
    chk_flag(irq === 1'b0);
    // second half: prescaled steps, 24 bit match, pwm duty
    apb(1, OFS_PRE, 32'h0000_0300); apb(1, OFS_PMT, 32'h0000_0700);
    apb(1, OFS_MTCH_B, 32'h2); apb(1, OFS_CTL, 32'h1 << CTL_RUN_B);
    apb(1, OFS_LOAD_B, 32'h1000); apb(0, OFS_VAL_B, 0); r2 = r;
    repeat (5) @(posedge clock);
    apb(0, OFS_VAL_B, 0); chk_flag((r2 - r) inside {[1:4]});
    apb(1, OFS_LOAD_B, 32'h4); repeat (40) @(posedge clock);
    apb(0, OFS_RIS, 0); chk_flag(r[IRQ_TO_B] && !r[IRQ_MT_B]);
    apb(1, OFS_PMT, 32'h0000_0200); repeat (40) @(posedge clock);
    apb(0, OFS_RIS, 0); chk_flag(r[IRQ_MT_B]);
    // two whole periods of 20 cycles, low two of five values below match
    hi = 32'h0;
    repeat (40) begin
      @(posedge clock); #1;
      hi += {31'h0, pwm_b};
    end
    chk_val(hi, 32'h10);
    apb(1, OFS_CTL, 0);
    // combined count ignores the prescaler; only first half registers used
    apb(1, OFS_PRE, 32'h0000_0303); apb(1, OFS_CFG, 32'h1 << CFG_COMB);
    apb(1, OFS_LOAD_A, 32'h0012_3456); apb(1, OFS_MTCH_A, 32'hffff_ffff);
    apb(0, OFS_LOAD_A, 0); chk_val(r, 32'h0012_3456);
    apb(1, OFS_CTL, 32'h1 << CTL_RUN_A); apb(0, OFS_VAL_A, 0); r2 = r;
    repeat (5) @(posedge clock); #1;
    chk_flag(pwm_a);
    apb(0, OFS_VAL_A, 0); chk_flag((r2 - r) inside {[6:20]});
    chk_val(r >> 16, 32'h0000_0012);
    apb(1, OFS_CTL, 0);
    give_verdict();
  end
endmodule : test_dual_half_timer_prescale_rtc
`default_nettype wire
